// [hw/mmii_core.v]
// Multi-master two-wire serial interface with Avalon-MM register access.
// Assumes open-drain pads outside: an enable high pulls the line low.
// Summary of operation
// - Works as master transmitter, master receiver, slave transmitter, slave receiver.
// - Rests in slave mode whenever idle.
// - Start is SDA falling while SCL high.
// - Stop is SDA rising while SCL high; only masters make them.
// - Entering master mode starts the transfer and drives SCL.
// - Busy set by start condition, cleared by next stop.
// - First byte is 7-bit address plus direction bit, 1 means read.
// - Master may issue repeated start with new address.
// - Bytes are 8 bits MSB first, each followed by acknowledge.
// - Acknowledge on ninth clock, always clocked by master.
// - Transmitter releases SDA on ninth clock, receiver pulls low.
// - Acknowledge enable bit 7 decides whether receiver acknowledges.
// - Transmitter holds SCL low until next byte written.
// - Receiver holds SCL low until received byte read.
// - Master sending high but seeing low loses arbitration.
// - After loss, SCL pulses continue only to end of byte.
// - Loss during address switches at once to slave receiver.
// - Unacknowledged address makes master stop and abandon transfer.
// - Master receiver ends read by not acknowledging last byte.
// - Four-bit prescaler field sets SCL frequency.
// - Own slave address register has no reset value.
// - Prescaler input is fosc/16 or fosc/512, chosen by bit 6.
// - Pending bit 4 sticks until written zero; bit 5 enables interrupt.
// - Received address compared with own address sets match status.
// - Status bit 4 gates data register writes; reads always allowed.
`timescale 1ns/10ps
`default_nettype none
`include "mmii_regs.vh"

module mmii_core (
	input  wire        clk,
	input  wire        nrst,
	input  wire [7:0]  avs_address,
	input  wire        avs_read,
	input  wire        avs_write,
	input  wire [31:0] avs_writedata,
	output wire [31:0] avs_readdata,
	output wire        avs_waitrequest,
	input  wire        scl_in,
	output wire        scl_out,
	output wire        scl_oe,
	input  wire        sda_in,
	output wire        sda_out,
	output wire        sda_oe,
	output wire        int_req
);

	localparam ST_IDLE   = 3'd0;
	localparam ST_MSTART = 3'd1;
	localparam ST_MBIT   = 3'd2;
	localparam ST_MWAIT  = 3'd3;
	localparam ST_MSTOP  = 3'd4;
	localparam ST_SBIT   = 3'd5;
	localparam ST_SWAIT  = 3'd6;

	reg  [2:0]  state_ff;
	reg  [1:0]  phase_ff;
	reg  [3:0]  bcnt_ff;
	reg  [7:0]  shift_ff;
	reg  [7:0]  own_ff;
	reg         ack_en_ff, clk_sel_ff, int_en_ff, pend_ff;
	reg  [3:0]  psc_ff;
	reg         mst_ff, tx_ff, busy_ff, soe_ff;
	reg         arbl_ff, match_ff, gc_ff, lrb_ff;
	reg         adr_ff, lost_ff;
	reg         scl_oe_ff, sda_oe_ff, int_ff;
	reg         wait_ff;
	reg  [7:0]  rdata_ff;
	reg  [7:0]  rmux;
	wire        nxt_wait;
	wire [5:0]  idx;
	wire        wr, rd, wr_ctrl, wr_stat, wr_data, wr_addr, rd_data;
	wire [7:0]  wd;
	wire        scl_s, sda_s, scl_rise, scl_fall, start_det, stop_det;
	wire        qt;
	wire        go_start, go_stop, resume;

	mmii_sync u_sync (
		.clk       (clk),
		.nrst      (nrst),
		.scl_in    (scl_in),
		.sda_in    (sda_in),
		.scl_s     (scl_s),
		.sda_s     (sda_s),
		.scl_rise  (scl_rise),
		.scl_fall  (scl_fall),
		.start_det (start_det),
		.stop_det  (stop_det)
	);

	mmii_presc u_presc (
		.clk     (clk),
		.nrst    (nrst),
		.clk_sel (clk_sel_ff),
		.psc     (psc_ff),
		.qtick   (qt)
	);

	// Bus decode; an access completes on the edge with waitrequest low
	assign idx      = avs_address[7:2];
	assign wd       = avs_writedata[7:0];
	assign wr       = avs_write & ~wait_ff;
	assign rd       = avs_read & ~wait_ff;
	assign wr_ctrl  = wr & (idx == `MMII_IDX_CTRL);
	assign wr_stat  = wr & (idx == `MMII_IDX_STAT);
	assign wr_data  = wr & (idx == `MMII_IDX_DATA) & soe_ff;
	assign wr_addr  = wr & (idx == `MMII_IDX_ADDR);
	assign rd_data  = rd & (idx == `MMII_IDX_DATA);
	assign nxt_wait = ~((avs_read | avs_write) & wait_ff);

	// Software commands: start and stop from a status write, resume from a data access
	assign go_start = wr_stat & wd[`MMII_STAT_MST] & wd[`MMII_STAT_BUSY];
	assign go_stop  = wr_stat & ~wd[`MMII_STAT_BUSY];
	assign resume   = tx_ff ? wr_data : rd_data;

	// Read mux; unmapped words read as zero
	always @* begin
		case (idx)
		`MMII_IDX_CTRL: rmux = {ack_en_ff, clk_sel_ff, int_en_ff,
			pend_ff, psc_ff};
		`MMII_IDX_STAT: rmux = {mst_ff, tx_ff, busy_ff, soe_ff,
			arbl_ff, match_ff, gc_ff, lrb_ff};
		`MMII_IDX_DATA: rmux = shift_ff;
		`MMII_IDX_ADDR: rmux = {own_ff[7:1], 1'b0};
		default:        rmux = 8'h00;
		endcase
	end

	// Bus handshake: one wait cycle, then the answer stands for one edge
	always @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			wait_ff  <= 1'b1;
			rdata_ff <= 8'h00;
		end else begin
			wait_ff <= nxt_wait;
			if ((avs_read | avs_write) & wait_ff)
				rdata_ff <= rmux;
		end
	end

	// Own address has no reset, so software must load it before use
	always @(posedge clk) begin
		if (wr_addr)
			own_ff <= wd;
	end

	// Registers and bus state machine; later assignments win, so a
	// hardware set in the same cycle beats a software clear
	always @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			{ack_en_ff, clk_sel_ff, int_en_ff, pend_ff, psc_ff}
				<= `MMII_CTRL_RST;
			{mst_ff, tx_ff, busy_ff, soe_ff, arbl_ff, match_ff,
				gc_ff, lrb_ff} <= `MMII_STAT_RST;
			state_ff  <= ST_IDLE;
			phase_ff  <= 2'd0;
			bcnt_ff   <= 4'd0;
			shift_ff  <= 8'h00;
			adr_ff    <= 1'b0;
			lost_ff   <= 1'b0;
			scl_oe_ff <= 1'b0;
			sda_oe_ff <= 1'b0;
			int_ff    <= 1'b0;
		end else begin
			int_ff <= pend_ff & int_en_ff;
			if (wr_ctrl) begin
				ack_en_ff  <= wd[`MMII_CTRL_ACKEN];
				clk_sel_ff <= wd[`MMII_CTRL_CLKSEL];
				int_en_ff  <= wd[`MMII_CTRL_INTEN];
				psc_ff     <= wd[`MMII_CTRL_PSC_HI:0];
				if (!wd[`MMII_CTRL_PEND])
					pend_ff <= 1'b0;
			end
			if (wr_stat) begin
				soe_ff  <= wd[`MMII_STAT_SOE];
				tx_ff   <= wd[`MMII_STAT_TX];
				arbl_ff <= 1'b0;
			end
			if (wr_data)
				shift_ff <= wd;
			// Busy follows the line, whoever drives it
			if (start_det)
				busy_ff <= 1'b1;
			else if (stop_det)
				busy_ff <= 1'b0;

			case (state_ff)
			ST_IDLE: begin
				mst_ff    <= 1'b0;
				scl_oe_ff <= 1'b0;
				sda_oe_ff <= 1'b0;
				if (go_start && !busy_ff) begin
					state_ff <= ST_MSTART;
					phase_ff <= 2'd0;
					mst_ff   <= 1'b1;
				end else if (start_det) begin
					state_ff <= ST_SBIT;
					bcnt_ff  <= 4'd0;
					adr_ff   <= 1'b1;
					tx_ff    <= 1'b0;
					match_ff <= 1'b0;
					gc_ff    <= 1'b0;
				end
			end
			// Also used for repeated start from a held-low clock
			ST_MSTART: if (qt) begin
				phase_ff <= phase_ff + 2'd1;
				case (phase_ff)
				2'd0: sda_oe_ff <= 1'b0;
				2'd1: scl_oe_ff <= 1'b0;
				2'd2: begin
					if (scl_s)
						sda_oe_ff <= 1'b1;
					else
						phase_ff <= 2'd2;
				end
				default: begin
					scl_oe_ff <= 1'b1;
					state_ff  <= ST_MBIT;
					bcnt_ff   <= 4'd0;
					adr_ff    <= 1'b1;
					lost_ff   <= 1'b0;
				end
				endcase
			end
			ST_MBIT: if (qt) begin
				phase_ff <= phase_ff + 2'd1;
				case (phase_ff)
				2'd0: begin
					if (bcnt_ff == 4'd8)
						sda_oe_ff <= ~tx_ff & ack_en_ff;
					else
						sda_oe_ff <= tx_ff & ~lost_ff
							& ~shift_ff[7];
				end
				2'd1: scl_oe_ff <= 1'b0;
				2'd2: begin
					// Wait out clock stretching before sampling
					if (!scl_s) begin
						phase_ff <= 2'd2;
					end else if (bcnt_ff == 4'd8) begin
						lrb_ff <= sda_s;
					end else begin
						shift_ff <= {shift_ff[6:0], sda_s};
						if (tx_ff && !lost_ff && shift_ff[7] && !sda_s) begin
							arbl_ff   <= 1'b1;
							sda_oe_ff <= 1'b0;
							lost_ff   <= 1'b1;
							if (adr_ff) begin
								state_ff <= ST_SBIT;
								mst_ff   <= 1'b0;
								tx_ff    <= 1'b0;
							end
						end
					end
				end
				default: begin
					scl_oe_ff <= 1'b1;
					if (bcnt_ff != 4'd8) begin
						bcnt_ff <= bcnt_ff + 4'd1;
					end else begin
						pend_ff <= 1'b1;
						bcnt_ff <= 4'd0;
						adr_ff  <= 1'b0;
						if (lost_ff) begin
							// Byte finished after a loss: let go of the bus
							state_ff  <= ST_IDLE;
							scl_oe_ff <= 1'b0;
						end else if (adr_ff && lrb_ff) begin
							state_ff <= ST_MSTOP;
							phase_ff <= 2'd0;
						end else begin
							state_ff <= ST_MWAIT;
							if (adr_ff)
								tx_ff <= ~shift_ff[0];
						end
					end
				end
				endcase
			end
			ST_MWAIT: begin
				phase_ff <= 2'd0;
				if (go_start)
					state_ff <= ST_MSTART;
				else if (go_stop)
					state_ff <= ST_MSTOP;
				else if (resume)
					state_ff <= ST_MBIT;
			end
			ST_MSTOP: if (qt) begin
				phase_ff <= phase_ff + 2'd1;
				case (phase_ff)
				2'd0: sda_oe_ff <= 1'b1;
				2'd1: scl_oe_ff <= 1'b0;
				2'd2: begin
					if (scl_s)
						sda_oe_ff <= 1'b0;
					else
						phase_ff <= 2'd2;
				end
				default: state_ff <= ST_IDLE;
				endcase
			end
			ST_SBIT: begin
				if (stop_det) begin
					state_ff  <= ST_IDLE;
					sda_oe_ff <= 1'b0;
				end else if (start_det) begin
					bcnt_ff   <= 4'd0;
					adr_ff    <= 1'b1;
					tx_ff     <= 1'b0;
					sda_oe_ff <= 1'b0;
				end else if (scl_rise) begin
					if (bcnt_ff == 4'd8)
						lrb_ff <= sda_s;
					else
						shift_ff <= {shift_ff[6:0], sda_s};
				end else if (scl_fall) begin
					if (bcnt_ff == 4'd7) begin
						bcnt_ff <= 4'd8;
						if (!adr_ff) begin
							sda_oe_ff <= ~tx_ff & ack_en_ff;
						end else if (shift_ff[7:1] == own_ff[7:1]) begin
							match_ff  <= 1'b1;
							sda_oe_ff <= ack_en_ff;
						end else if (shift_ff[7:1] == 7'h00) begin
							gc_ff     <= 1'b1;
							sda_oe_ff <= ack_en_ff;
						end else begin
							// Not for us: stay off the bus
							state_ff  <= ST_IDLE;
							sda_oe_ff <= 1'b0;
						end
					end else if (bcnt_ff == 4'd8) begin
						pend_ff   <= 1'b1;
						sda_oe_ff <= 1'b0;
						bcnt_ff   <= 4'd0;
						adr_ff    <= 1'b0;
						if (tx_ff && !adr_ff && lrb_ff) begin
							state_ff <= ST_IDLE;
						end else begin
							scl_oe_ff <= 1'b1;
							state_ff  <= ST_SWAIT;
							if (adr_ff)
								tx_ff <= shift_ff[0];
						end
					end else begin
						bcnt_ff   <= bcnt_ff + 4'd1;
						sda_oe_ff <= tx_ff & ~shift_ff[7];
					end
				end
			end
			ST_SWAIT: begin
				if (stop_det) begin
					state_ff  <= ST_IDLE;
					scl_oe_ff <= 1'b0;
				end else if (resume) begin
					scl_oe_ff <= 1'b0;
					sda_oe_ff <= tx_ff & ~wd[7];
					state_ff  <= ST_SBIT;
				end
			end
			default: state_ff <= ST_IDLE;
			endcase
		end
	end

	assign avs_readdata    = {24'h00_0000, rdata_ff};
	assign avs_waitrequest = wait_ff;
	assign scl_oe          = scl_oe_ff;
	assign sda_oe          = sda_oe_ff;
	assign scl_out         = 1'b0;
	assign sda_out         = 1'b0;
	assign int_req         = int_ff;

endmodule // mmii_core

`default_nettype wire

// [hw/mmii_presc.v]
// Serial clock prescaler: emits one pulse per quarter serial clock.
// Assumes control fields come from registers on the same clock.
`timescale 1ns/10ps
`default_nettype none
`include "mmii_regs.vh"

module mmii_presc (
	input  wire       clk,
	input  wire       nrst,
	input  wire       clk_sel,
	input  wire [3:0] psc,
	output wire       qtick
);

	reg  [8:0] base_ff;
	reg  [3:0] pcnt_ff;
	reg        qtick_ff;
	wire [8:0] base_lim;
	wire       base_tick;

	// Quarter of fosc/16 or fosc/512 keeps four phases per period
	assign base_lim  = clk_sel ? `MMII_BASE_SLOW : `MMII_BASE_FAST;
	assign base_tick = (base_ff >= base_lim);

	// Divide by prescaler plus one; four ticks make one serial clock
	always @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			base_ff  <= 9'h000;
			pcnt_ff  <= 4'h0;
			qtick_ff <= 1'b0;
		end else begin
			qtick_ff <= 1'b0;
			base_ff  <= base_tick ? 9'h000 : base_ff + 9'h001;
			if (base_tick) begin
				if (pcnt_ff >= psc) begin
					pcnt_ff  <= 4'h0;
					qtick_ff <= 1'b1;
				end else begin
					pcnt_ff <= pcnt_ff + 4'h1;
				end
			end
		end
	end

	assign qtick = qtick_ff;

endmodule // mmii_presc

`default_nettype wire

// [hw/mmii_regs.vh]
// Register map, field positions, reset values and clock division
// constants of the multi-master two-wire serial interface.
// Assumes a 32-bit Avalon-MM slave with byte addresses; each register
// sits in the low byte of one aligned word at four times its index.
`ifndef MMII_REGS_VH
`define MMII_REGS_VH

// Register indices; byte address is four times the index
`define MMII_IDX_CTRL      6'h0C
`define MMII_IDX_STAT      6'h0D
`define MMII_IDX_DATA      6'h0E
`define MMII_IDX_ADDR      6'h0F

// Control register fields
`define MMII_CTRL_ACKEN    7
`define MMII_CTRL_CLKSEL   6
`define MMII_CTRL_INTEN    5
`define MMII_CTRL_PEND     4
`define MMII_CTRL_PSC_HI   3

// Status register fields (bits 2..0 read only; any status write clears bit 3)
`define MMII_STAT_MST      7
`define MMII_STAT_TX       6
`define MMII_STAT_BUSY     5
`define MMII_STAT_SOE      4
`define MMII_STAT_ARBL     3
`define MMII_STAT_MATCH    2
`define MMII_STAT_GCALL    1
`define MMII_STAT_LRB      0

// Reset values
`define MMII_CTRL_RST      8'h00
`define MMII_STAT_RST      8'h00

// Quarter-period base dividers: fosc/16 and fosc/512, split in four
`define MMII_BASE_FAST     9'h003
`define MMII_BASE_SLOW     9'h07F

`endif

// [hw/mmii_sync.v]
// Two-flop synchronisers for the bus pins plus start, stop and clock
// edge detectors. Assumes asynchronous pins and one system clock.
`timescale 1ns/10ps
`default_nettype none

module mmii_sync (
	input  wire       clk,
	input  wire       nrst,
	input  wire       scl_in,
	input  wire       sda_in,
	output wire       scl_s,
	output wire       sda_s,
	output wire       scl_rise,
	output wire       scl_fall,
	output wire       start_det,
	output wire       stop_det
);

	reg  [1:0] meta_ff;
	reg  [1:0] sync_ff;
	reg  [1:0] prev_ff;
	reg  [3:0] det_ff;

	// First stage feeds only the second; detectors look at later stages
	always @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			meta_ff <= 2'h3;
			sync_ff <= 2'h3;
			prev_ff <= 2'h3;
			det_ff  <= 4'h0;
		end else begin
			meta_ff <= {scl_in, sda_in};
			sync_ff <= meta_ff;
			prev_ff <= sync_ff;
			det_ff[0] <= prev_ff[1] & sync_ff[1] & prev_ff[0]
				& ~sync_ff[0];
			det_ff[1] <= prev_ff[1] & sync_ff[1] & ~prev_ff[0]
				& sync_ff[0];
			det_ff[2] <= ~prev_ff[1] & sync_ff[1];
			det_ff[3] <= prev_ff[1] & ~sync_ff[1];
		end
	end

	assign scl_s     = prev_ff[1];
	assign sda_s     = prev_ff[0];
	assign start_det = det_ff[0];
	assign stop_det  = det_ff[1];
	assign scl_rise  = det_ff[2];
	assign scl_fall  = det_ff[3];

endmodule // mmii_sync

`default_nettype wire

// [tb/mmii_props.sv]
// Checker for the register bus and pin outputs of the serial core.
// Assumes it is bound into mmii_core and runs on the one system clock.
`timescale 1ns/10ps
`default_nettype none

module mmii_props (
	input wire logic        clk,
	input wire logic        nrst,
	input wire logic [7:0]  avs_address,
	input wire logic        avs_read,
	input wire logic        avs_write,
	input wire logic [31:0] avs_writedata,
	input wire logic [31:0] avs_readdata,
	input wire logic        avs_waitrequest,
	input wire logic        scl_in,
	input wire logic        scl_out,
	input wire logic        scl_oe,
	input wire logic        sda_in,
	input wire logic        sda_out,
	input wire logic        sda_oe,
	input wire logic        int_req
);
	logic [3:0] wc_ff;

	// Recent control writes; only they may clear pending or its enable
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			wc_ff <= 4'h0;
		end else begin
			wc_ff <= {wc_ff[2:0], avs_write && !avs_waitrequest &&
				avs_address[7:2] == 6'h0C};
		end
	end

	default clocking cb @(posedge clk); endclocking
	default disable iff (!nrst);

	sequence s_req;
		(avs_read || avs_write) && avs_waitrequest;
	endsequence
	sequence s_done;
		!avs_waitrequest ##1 avs_waitrequest;
	endsequence

	property p_wait_ans;
		s_req |=> s_done;
	endproperty
	a_wait_ans: assert property (p_wait_ans) else $error("late answer");
	property p_wait_idle;
		!avs_read && !avs_write |-> avs_waitrequest;
	endproperty
	a_wait_idle: assert property (p_wait_idle) else $error("idle ready");
	property p_wait_one;
		!avs_waitrequest |=> avs_waitrequest;
	endproperty
	a_wait_one: assert property (p_wait_one) else $error("long ready");
	property p_unmapped;
		avs_read && !avs_waitrequest && avs_address[7:4] != 4'h3
			|-> avs_readdata == 32'h0000_0000;
	endproperty
	a_unmapped: assert property (p_unmapped) else $error("unmapped data");
	property p_hi_zero;
		avs_read && !avs_waitrequest |-> avs_readdata[31:8] == 24'h00_0000;
	endproperty
	a_hi_zero: assert property (p_hi_zero) else $error("upper bits set");
	property p_pins;
		scl_out == 1'b0 && sda_out == 1'b0;
	endproperty
	a_pins: assert property (p_pins) else $error("pin driven high");
	property p_int_fall;
		$fell(int_req) |-> |wc_ff;
	endproperty
	a_int_fall: assert property (p_int_fall) else $error("pending lost");
	property p_int_rise;
		$rose(int_req) |-> scl_oe || |wc_ff;
	endproperty
	a_int_rise: assert property (p_int_rise) else $error("clock not held");
endmodule // mmii_props

bind mmii_core mmii_props u_props (.clk(clk), .nrst(nrst),
	.avs_address(avs_address), .avs_read(avs_read),
	.avs_write(avs_write), .avs_writedata(avs_writedata),
	.avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
	.scl_in(scl_in), .scl_out(scl_out), .scl_oe(scl_oe),
	.sda_in(sda_in), .sda_out(sda_out), .sda_oe(sda_oe),
	.int_req(int_req));
`default_nettype wire

// [tb/mmii_slave_model.sv]
// Behavioural slave receiver standing on the two-wire bus.
// Assumes pulled-up lines; pull_sda high drags SDA low.
`timescale 1ns/10ps
`default_nettype none

module mmii_slave_model #(
	parameter logic [6:0] OWN_ADDR = 7'h52
) (
	input  wire logic       scl,
	input  wire logic       sda,
	output var  logic       pull_sda,
	output var  logic [7:0] last_byte
);
	logic [7:0] sh;
	logic       first;
	logic       sel;

	initial pull_sda = 1'b0;
	initial last_byte = 8'h00;

	// One frame per start; no clock stretching, so it never stalls
	always @(negedge sda) begin : frame
		if (scl === 1'b1) begin
			first = 1'b1;
			sel = 1'b0;
			forever begin
				repeat (8) @(posedge scl) sh = {sh[6:0], sda};
				@(negedge scl);
				last_byte = sh;
				if (first) sel = (sh[7:1] == OWN_ADDR);
				first = 1'b0;
				pull_sda <= sel;
				@(negedge scl);
				pull_sda <= 1'b0;
			end
		end
	end

	// Stop ends the frame wherever it stands
	always @(posedge sda) begin
		if (scl === 1'b1) begin
			disable frame;
			pull_sda <= 1'b0;
		end
	end
endmodule // mmii_slave_model
`default_nettype wire

// [tb/test_multi_master_i2c_interface.sv]
// Bench: registers, master write, refused address, busy bus, arbitration.
// Assumes the slave model on a pulled-up bus at address 7'h52.
`timescale 1ns/10ps
`default_nettype none
`include "mmii_regs.vh"
`define CHK(g, e) begin n_checks++; if ((g) !== (e)) begin mismatches++; \
	$display("mismatch t=%0t got=%h exp=%h", $time, (g), (e)); end end

module test_multi_master_i2c_interface;
	localparam logic [7:0] A_CTRL = {`MMII_IDX_CTRL, 2'b00};
	localparam logic [7:0] A_STAT = {`MMII_IDX_STAT, 2'b00};
	localparam logic [7:0] A_DATA = {`MMII_IDX_DATA, 2'b00};
	logic        clk;
	logic        nrst;
	logic [7:0]  avs_address;
	logic        avs_read;
	logic        avs_write;
	logic [31:0] avs_writedata;
	logic [31:0] avs_readdata;
	logic        avs_waitrequest;
	logic        scl_oe;
	logic        sda_oe;
	logic        int_req;
	logic        pull_sda;
	logic [7:0]  last_byte;
	logic [7:0]  q;
	logic        rival;
	int          w;
	int          mismatches = 0;
	int          n_checks = 0;
	// Wired-AND over pull-ups; only the core drives SCL
	wire         scl = !scl_oe;
	// A second master on the line is modelled by rival pulling SDA low
	wire         sda = !(sda_oe || pull_sda || rival);

	mmii_core dut (.clk(clk), .nrst(nrst), .avs_address(avs_address),
		.avs_read(avs_read), .avs_write(avs_write),
		.avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
		.avs_waitrequest(avs_waitrequest), .scl_in(scl), .scl_out(),
		.scl_oe(scl_oe), .sda_in(sda), .sda_out(), .sda_oe(sda_oe),
		.int_req(int_req));
	mmii_slave_model #(.OWN_ADDR(7'h52)) u_slave (.scl(scl), .sda(sda),
		.pull_sda(pull_sda), .last_byte(last_byte));

	always #4 clk = ~clk;

	task automatic print_verdict();
		$display("checks %0d mismatches %0d", n_checks, mismatches);
		if (mismatches == 0 && n_checks > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask

	// One bus cycle; request held until waitrequest is sampled low
	task automatic bus(input logic wr, input logic [7:0] a,
		input logic [7:0] d, output logic [7:0] r);
		int n;
		n = 0;
		@(posedge clk);
		avs_address <= a;
		avs_write <= wr;
		avs_read <= !wr;
		avs_writedata <= {24'h00_0000, d};
		do begin
			@(posedge clk);
			n++;
		end while (avs_waitrequest !== 1'b0 && n < 50);
		// Data and completion are both taken at this same rising edge
		r = avs_readdata[7:0];
		avs_write <= 1'b0;
		avs_read <= 1'b0;
		if (avs_waitrequest !== 1'b0) begin
			mismatches++;
			print_verdict();
		end
	endtask

	task automatic rdchk(input logic [7:0] a, input logic [7:0] e);
		bus(1'b0, a, 8'h00, q);
		`CHK(q, e)
	endtask

	// Bounded poll until the masked register matches
	task automatic poll(input logic [7:0] a, input logic [7:0] m,
		input logic [7:0] v);
		int k;
		for (k = 0; k < 300; k++) begin
			bus(1'b0, a, 8'h00, q);
			if ((q & m) === v) break;
		end
		if (k == 300) begin
			mismatches++;
			print_verdict();
		end
	endtask

	initial begin
		clk = 1'b0;
		nrst = 1'b0;
		avs_address = 8'h00;
		avs_read = 1'b0;
		avs_write = 1'b0;
		avs_writedata = 32'h0000_0000;
		rival = 1'b0;
		repeat (5) @(posedge clk);
		nrst <= 1'b1;
		rdchk(A_CTRL, `MMII_CTRL_RST);
		rdchk(A_STAT, `MMII_STAT_RST);
		bus(1'b1, A_CTRL, 8'hBF, q);
		rdchk(A_CTRL, 8'hAF);
		bus(1'b1, A_STAT, 8'h1F, q);
		rdchk(A_STAT, 8'h10);
		bus(1'b1, A_DATA, 8'h5A, q);
		bus(1'b1, A_STAT, 8'h00, q);
		bus(1'b1, A_DATA, 8'hC3, q);
		rdchk(A_DATA, 8'h5A);
		bus(1'b1, 8'h04, 8'hFF, q);
		rdchk(8'h04, 8'h00);
		$display("register test done");
		// Master write: address byte then one data byte
		bus(1'b1, A_CTRL, 8'hA0, q);
		bus(1'b1, A_STAT, 8'h10, q);
		bus(1'b1, A_DATA, 8'hA4, q);
		bus(1'b1, A_STAT, 8'hF0, q);
		poll(A_CTRL, 8'h10, 8'h10);
		rdchk(A_STAT, 8'hF0);
		`CHK(last_byte, 8'hA4)
		`CHK(int_req, 1'b1)
		repeat (40) @(posedge clk);
		`CHK(scl, 1'b0)
		rdchk(A_CTRL, 8'hB0);
		bus(1'b1, A_CTRL, 8'hA0, q);
		rdchk(A_CTRL, 8'hA0);
		bus(1'b1, A_DATA, 8'h3C, q);
		poll(A_CTRL, 8'h10, 8'h10);
		`CHK(last_byte, 8'h3C)
		rdchk(A_STAT, 8'hF0);
		bus(1'b1, A_CTRL, 8'hA0, q);
		bus(1'b1, A_STAT, 8'hD0, q);
		poll(A_STAT, 8'hA0, 8'h00);
		`CHK({scl, sda}, 2'b11)
		$display("master write test done");
		// Address nobody answers: master must stop by itself
		bus(1'b1, A_DATA, 8'hB0, q);
		bus(1'b1, A_STAT, 8'hF0, q);
		poll(A_STAT, 8'hA1, 8'h01);
		`CHK(last_byte, 8'hB0)
		`CHK({scl, sda}, 2'b11)
		$display("refused address test done");
		// Another master starts first: our start is refused, we stay slave
		rival <= 1'b1;
		poll(A_STAT, 8'h20, 8'h20);
		rdchk(A_STAT, 8'h31);
		bus(1'b1, A_STAT, 8'hF0, q);
		rdchk(A_STAT, 8'h71);
		rival <= 1'b0;
		poll(A_STAT, 8'hA0, 8'h00);
		$display("busy bus test done");
		// Lose the first address bit to the other master
		bus(1'b1, A_DATA, 8'hB0, q);
		bus(1'b1, A_STAT, 8'hF0, q);
		for (w = 0; w < 200 && sda; w++)
			@(posedge clk);
		if (sda) begin
			mismatches++;
			print_verdict();
		end
		rival <= 1'b1;
		poll(A_STAT, 8'h88, 8'h08);
		rival <= 1'b0;
		poll(A_STAT, 8'h20, 8'h00);
		rdchk(A_STAT, 8'h19);
		`CHK({scl, sda}, 2'b11)
		$display("arbitration test done");
		print_verdict();
	end
endmodule // test_multi_master_i2c_interface
`default_nettype wire
